// file: hw/fegt_regs.vh
/*
  Offsets, field positions, reset values and frame sizes of the front-end
  gain and termination register bank.
  Assumes it is included by the bank module only.
*/
`ifndef FEGT_REGS_VH
`define FEGT_REGS_VH

// Register offsets on the serial port
`define FEGT_ADDR_FILTER_AMP    8'h33
`define FEGT_ADDR_INPUT_TERM    8'h34
`define FEGT_ADDR_POWER_MODE    8'h35

// Serial frame: address byte then data word, MSB first
`define FEGT_ADDR_BITS          8
`define FEGT_DATA_BITS          16
`define FEGT_FRAME_BITS         5'h18
`define FEGT_ADDR_DONE          5'h08

// filter_amp_config fields
`define FEGT_LPF_MSB            3
`define FEGT_LPF_LSB            1
`define FEGT_SAMP_LOOP_BIT      4
`define FEGT_SAMP_LIMIT_MSB     7
`define FEGT_SAMP_LIMIT_LSB     5
`define FEGT_SAMP_GAIN_BIT      13
`define FEGT_FILTER_AMP_MASK    16'h20FE

// input_termination_config fields
`define FEGT_TERM_IND_MSB       4
`define FEGT_TERM_IND_LSB       0
`define FEGT_TERM_IND_EN_BIT    5
`define FEGT_TERM_PRESET_MSB    7
`define FEGT_TERM_PRESET_LSB    6
`define FEGT_TERM_EN_BIT        8
`define FEGT_INLIM_MSB          10
`define FEGT_INLIM_LSB          9
`define FEGT_IAMP_LOOP_BIT      12
`define FEGT_IAMP_GAIN_MSB      14
`define FEGT_IAMP_GAIN_LSB      13
`define FEGT_INPUT_TERM_MASK    16'h77FF

// Power mode field of the power register
`define FEGT_PMODE_MSB          11
`define FEGT_PMODE_LSB          10
`define FEGT_POWER_MODE_MASK    16'h0C00

// Field codes
`define FEGT_LPF_15M            3'h0
`define FEGT_LPF_20M            3'h2
`define FEGT_LPF_30M            3'h3
`define FEGT_LPF_10M            3'h4
`define FEGT_PMODE_LOW_NOISE    2'h0
`define FEGT_PMODE_LOW_POWER    2'h1
`define FEGT_PMODE_MED_POWER    2'h2
`define FEGT_IAMP_GAIN_18DB     2'h0
`define FEGT_IAMP_GAIN_24DB     2'h1
`define FEGT_IAMP_GAIN_12DB     2'h2
`define FEGT_INLIM_AUTO         2'h0
`define FEGT_INLIM_1V50         2'h1
`define FEGT_INLIM_1V15         2'h2
`define FEGT_INLIM_0V60         2'h3

// Reset values
`define FEGT_RESET_WORD         16'h0000

`endif

// file: hw/fegt_bank.v
/*
  Front-end gain and termination configuration bank: serial write/read
  port, three stored configuration words and registered decode of every
  field into analog control lines.
  Assumes serial port pins are already synchronous to clock and that
  the serial clock runs well below a quarter of the system clock.
*/
// Contract
// - LPF code picks 15/20/30/10 MHz
// - Second amp loop bit disables its integrator
// - Low-noise mode: 000 -2dBFS, 010 0dBFS, 1XX off
// - Low/medium power: 100 -2dBFS, 110 0dBFS, 0XX off
// - Second amp gain bit: 24 or 30 dB
// - Individual resistor field needs its enable bit
// - Preset picks 50/100/200/400 ohm, mapping derived
// - Preset 00 at 12 dB means high impedance
// - Termination enable bit switches termination
// - Input clamp: auto, 1.5, 1.15, 0.6 Vpp
// - Input amp loop bit disables its integrator
// - Power mode: low noise, low, medium power
// - Input amp gain: 18, 24, 12 dB
`timescale 1ns/1ps
`include "fegt_regs.vh"

module fegt_bank #(
  parameter [4:0] TERM_MAP_50  = 5'h01,
  parameter [4:0] TERM_MAP_100 = 5'h02,
  parameter [4:0] TERM_MAP_200 = 5'h04,
  parameter [4:0] TERM_MAP_400 = 5'h08
) (
  // Clock and reset
  input  wire        clock,
  input  wire        sys_rst,
  // Serial configuration port
  input  wire        cfg_sclk,
  input  wire        cfg_sen_n,
  input  wire        cfg_sdata,
  input  wire        cfg_read_en,
  output wire        cfg_sdout,
  // Low-pass filter, one-hot 10/15/20/30 MHz
  output wire [3:0]  lowpass_cutoff_select,
  // Second amplifier
  output wire        second_amp_offset_loop_off,
  output wire        second_amp_highpass_off,
  output wire        second_amp_limit_on,
  output wire        second_amp_output_limit_level,
  output wire        second_amp_gain_select,
  // Input termination
  output wire        term_active_on,
  output wire        term_high_z,
  output wire [4:0]  term_resistor_map,
  // Input amplifier, limit one-hot auto/1.5/1.15/0.6 Vpp
  output wire [3:0]  input_limit_select,
  output wire        input_amp_offset_loop_off,
  output wire        input_amp_highpass_off,
  output wire [2:0]  input_amp_gain_select,
  // Power mode, one-hot low noise/low power/medium power
  output wire [2:0]  power_mode_select
);

  reg  [15:0] filter_amp_config_ff;
  reg  [15:0] input_termination_config_ff;
  reg  [15:0] power_mode_config_ff;
  reg         sclk_prev_ff;
  reg  [4:0]  bit_cnt_ff;
  reg  [23:0] shift_in_ff;
  reg  [15:0] shift_out_ff;
  reg         sdout_ff;
  reg  [3:0]  lpf_ff;
  reg         samp_loop_ff;
  reg         samp_lim_on_ff;
  reg         samp_lim_lvl_ff;
  reg         samp_gain_ff;
  reg         term_on_ff;
  reg         term_hz_ff;
  reg  [4:0]  term_map_ff;
  reg  [3:0]  inlim_ff;
  reg         iamp_loop_ff;
  reg  [2:0]  iamp_gain_ff;
  reg  [2:0]  pmode_ff;

  reg  [3:0]  nxt_lpf;
  reg         nxt_samp_lim_on;
  reg         nxt_samp_lim_lvl;
  reg         nxt_term_hz;
  reg  [4:0]  nxt_term_map;
  reg  [3:0]  nxt_inlim;
  reg  [2:0]  nxt_iamp_gain;
  reg  [2:0]  nxt_pmode;
  reg  [15:0] rd_word;

  // Serial levels must each last at least one clock or an edge is missed
  wire        sclk_rise  = cfg_sclk & ~sclk_prev_ff;
  wire        sclk_fall  = ~cfg_sclk & sclk_prev_ff;
  wire        frame_on   = ~cfg_sen_n;
  wire [23:0] frame_word = {shift_in_ff[22:0], cfg_sdata};
  wire        frame_done = frame_on & sclk_rise & (bit_cnt_ff == `FEGT_FRAME_BITS - 5'h01);
  wire [7:0]  addr_now   = frame_word[7:0];
  wire        addr_done  = frame_on & sclk_rise & (bit_cnt_ff == `FEGT_ADDR_DONE - 5'h01);

  wire [2:0]  lpf_code   = filter_amp_config_ff[`FEGT_LPF_MSB:`FEGT_LPF_LSB];
  wire [2:0]  lim_code   = filter_amp_config_ff[`FEGT_SAMP_LIMIT_MSB:`FEGT_SAMP_LIMIT_LSB];
  wire [1:0]  preset     = input_termination_config_ff[`FEGT_TERM_PRESET_MSB:`FEGT_TERM_PRESET_LSB];
  wire        ind_en     = input_termination_config_ff[`FEGT_TERM_IND_EN_BIT];
  wire [1:0]  iamp_code  = input_termination_config_ff[`FEGT_IAMP_GAIN_MSB:`FEGT_IAMP_GAIN_LSB];
  wire [1:0]  inlim_code = input_termination_config_ff[`FEGT_INLIM_MSB:`FEGT_INLIM_LSB];
  wire [1:0]  pmode_code = power_mode_config_ff[`FEGT_PMODE_MSB:`FEGT_PMODE_LSB];
  wire        lim_flip   = (pmode_code == `FEGT_PMODE_LOW_POWER) |
                           (pmode_code == `FEGT_PMODE_MED_POWER);

  // Serial frame capture; a short frame is dropped when enable rises
  always @(posedge clock) begin
    if (sys_rst) begin
      sclk_prev_ff <= 1'b0;
      bit_cnt_ff   <= 5'h00;
      shift_in_ff  <= 24'h000000;
    end else begin
      sclk_prev_ff <= cfg_sclk;
      if (!frame_on) begin
        bit_cnt_ff <= 5'h00;
      end else if (sclk_rise) begin
        shift_in_ff <= frame_word;
        if (frame_done) begin
          bit_cnt_ff <= 5'h00;
        end else begin
          bit_cnt_ff <= bit_cnt_ff + 5'h01;
        end
      end
    end
  end

  // Only documented fields are stored, so stray reserved bits read zero
  // A read frame never writes, so reading cannot disturb the word
  always @(posedge clock) begin
    if (sys_rst) begin
      filter_amp_config_ff        <= `FEGT_RESET_WORD;
      input_termination_config_ff <= `FEGT_RESET_WORD;
      power_mode_config_ff        <= `FEGT_RESET_WORD;
    end else if (frame_done && !cfg_read_en) begin
      if (frame_word[23:16] == `FEGT_ADDR_FILTER_AMP) begin
        filter_amp_config_ff <= frame_word[15:0] & `FEGT_FILTER_AMP_MASK;
      end else if (frame_word[23:16] == `FEGT_ADDR_INPUT_TERM) begin
        input_termination_config_ff <= frame_word[15:0] & `FEGT_INPUT_TERM_MASK;
      end else if (frame_word[23:16] == `FEGT_ADDR_POWER_MODE) begin
        power_mode_config_ff <= frame_word[15:0] & `FEGT_POWER_MODE_MASK;
      end
    end
  end

  // Read-back word for the address just received
  always @* begin
    if (addr_now == `FEGT_ADDR_FILTER_AMP) begin
      rd_word = filter_amp_config_ff;
    end else if (addr_now == `FEGT_ADDR_INPUT_TERM) begin
      rd_word = input_termination_config_ff;
    end else if (addr_now == `FEGT_ADDR_POWER_MODE) begin
      rd_word = power_mode_config_ff;
    end else begin
      rd_word = 16'h0000;
    end
  end

  // Read data changes on falling serial edges so the host samples on rising
  // Held low outside read frames so the pin idles at a known level
  always @(posedge clock) begin
    if (sys_rst) begin
      shift_out_ff <= 16'h0000;
      sdout_ff     <= 1'b0;
    end else if (!frame_on || !cfg_read_en) begin
      shift_out_ff <= 16'h0000;
      sdout_ff     <= 1'b0;
    end else if (addr_done) begin
      shift_out_ff <= rd_word;
    end else if (sclk_fall && bit_cnt_ff >= `FEGT_ADDR_DONE) begin
      sdout_ff     <= shift_out_ff[15];
      shift_out_ff <= {shift_out_ff[14:0], 1'b0};
    end
  end

  // Low-pass cutoff decode
  always @* begin
    case (lpf_code)
      `FEGT_LPF_10M: nxt_lpf = 4'h1;
      `FEGT_LPF_20M: nxt_lpf = 4'h4;
      `FEGT_LPF_30M: nxt_lpf = 4'h8;
      // Unlisted codes fall back to the reset cutoff
      default:       nxt_lpf = 4'h2;
    endcase
  end

  // Clamp sense flips between power modes; bit 1 picks the level
  // Reserved power code shows as low noise, so the clamp keeps that sense
  always @* begin
    if (lim_flip) begin
      nxt_samp_lim_on = lim_code[2];
    end else begin
      nxt_samp_lim_on = ~lim_code[2];
    end
    nxt_samp_lim_lvl = nxt_samp_lim_on & lim_code[1];
  end

  // Preset mapping unless individual control is enabled
  always @* begin
    if (ind_en) begin
      nxt_term_map = input_termination_config_ff[`FEGT_TERM_IND_MSB:`FEGT_TERM_IND_LSB];
      nxt_term_hz  = 1'b0;
    end else begin
      case (preset)
        2'h0:    nxt_term_map = TERM_MAP_50;
        2'h1:    nxt_term_map = TERM_MAP_100;
        2'h2:    nxt_term_map = TERM_MAP_200;
        default: nxt_term_map = TERM_MAP_400;
      endcase
      nxt_term_hz = (preset == 2'h0) && (iamp_code == `FEGT_IAMP_GAIN_12DB);
      if (nxt_term_hz) begin
        nxt_term_map = 5'h00;
      end
    end
  end

  // Input clamp decode
  always @* begin
    case (inlim_code)
      `FEGT_INLIM_AUTO: nxt_inlim = 4'h1;
      `FEGT_INLIM_1V50: nxt_inlim = 4'h2;
      `FEGT_INLIM_1V15: nxt_inlim = 4'h4;
      default:          nxt_inlim = 4'h8;
    endcase
  end

  // Input amplifier gain decode
  always @* begin
    case (iamp_code)
      `FEGT_IAMP_GAIN_18DB: nxt_iamp_gain = 3'h2;
      `FEGT_IAMP_GAIN_24DB: nxt_iamp_gain = 3'h4;
      `FEGT_IAMP_GAIN_12DB: nxt_iamp_gain = 3'h1;
      // Reserved code holds the reset gain
      default:              nxt_iamp_gain = 3'h2;
    endcase
  end

  // Power mode decode
  always @* begin
    case (pmode_code)
      `FEGT_PMODE_LOW_NOISE: nxt_pmode = 3'h1;
      `FEGT_PMODE_LOW_POWER: nxt_pmode = 3'h2;
      `FEGT_PMODE_MED_POWER: nxt_pmode = 3'h4;
      default:               nxt_pmode = 3'h1;
    endcase
  end

  // Registered control lines follow the stored words one cycle later
  // Reset values equal the decode of all-zero words, so release is glitch free
  always @(posedge clock) begin
    if (sys_rst) begin
      lpf_ff          <= 4'h2;
      samp_loop_ff    <= 1'b0;
      samp_lim_on_ff  <= 1'b1;
      samp_lim_lvl_ff <= 1'b0;
      samp_gain_ff    <= 1'b0;
      term_on_ff      <= 1'b0;
      term_hz_ff      <= 1'b0;
      term_map_ff     <= TERM_MAP_50;
      inlim_ff        <= 4'h1;
      iamp_loop_ff    <= 1'b0;
      iamp_gain_ff    <= 3'h2;
      pmode_ff        <= 3'h1;
    end else begin
      lpf_ff          <= nxt_lpf;
      samp_loop_ff    <= filter_amp_config_ff[`FEGT_SAMP_LOOP_BIT];
      samp_lim_on_ff  <= nxt_samp_lim_on;
      samp_lim_lvl_ff <= nxt_samp_lim_lvl;
      samp_gain_ff    <= filter_amp_config_ff[`FEGT_SAMP_GAIN_BIT];
      term_on_ff      <= input_termination_config_ff[`FEGT_TERM_EN_BIT];
      term_hz_ff      <= nxt_term_hz;
      term_map_ff     <= nxt_term_map;
      inlim_ff        <= nxt_inlim;
      iamp_loop_ff    <= input_termination_config_ff[`FEGT_IAMP_LOOP_BIT];
      iamp_gain_ff    <= nxt_iamp_gain;
      pmode_ff        <= nxt_pmode;
    end
  end

  // Offset-loop and high-pass disables share one stored bit each
  assign cfg_sdout                     = sdout_ff;
  assign lowpass_cutoff_select         = lpf_ff;
  assign second_amp_offset_loop_off    = samp_loop_ff;
  assign second_amp_highpass_off       = samp_loop_ff;
  assign second_amp_limit_on           = samp_lim_on_ff;
  assign second_amp_output_limit_level = samp_lim_lvl_ff;
  assign second_amp_gain_select        = samp_gain_ff;
  assign term_active_on                = term_on_ff;
  assign term_high_z                   = term_hz_ff;
  assign term_resistor_map             = term_map_ff;
  assign input_limit_select            = inlim_ff;
  assign input_amp_offset_loop_off     = iamp_loop_ff;
  assign input_amp_highpass_off        = iamp_loop_ff;
  assign input_amp_gain_select         = iamp_gain_ff;
  assign power_mode_select             = pmode_ff;

endmodule // fegt_bank

// file: tb/fegt_bank_sva.sv
/* Port assertions for the gain and termination bank.
   Assumes a bind from the bench top and a single clock domain. */
`timescale 1ns/1ps
module fegt_bank_sva (
  // Clock and reset
  input wire       clock,
  input wire       sys_rst,
  // Serial port
  input wire       cfg_sen_n,
  input wire       cfg_read_en,
  // Decoded controls
  input wire [3:0] lowpass_cutoff_select,
  input wire       second_amp_offset_loop_off,
  input wire       second_amp_highpass_off,
  input wire       second_amp_limit_on,
  input wire       second_amp_output_limit_level,
  input wire       second_amp_gain_select,
  input wire       term_active_on,
  input wire       term_high_z,
  input wire [4:0] term_resistor_map,
  input wire [3:0] input_limit_select,
  input wire       input_amp_offset_loop_off,
  input wire       input_amp_highpass_off,
  input wire [2:0] input_amp_gain_select,
  input wire [2:0] power_mode_select
);
  default clocking fegt_cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  wire [27:0] outs = {lowpass_cutoff_select, second_amp_offset_loop_off,
    second_amp_highpass_off, second_amp_limit_on, second_amp_output_limit_level,
    second_amp_gain_select, term_active_on, term_high_z, term_resistor_map,
    input_limit_select, input_amp_offset_loop_off, input_amp_highpass_off,
    input_amp_gain_select, power_mode_select};
  a_lpf_onehot: assert property ($onehot(lowpass_cutoff_select))
    else $error("cutoff select not one-hot");
  a_samp_loop_pair: assert property (second_amp_highpass_off == second_amp_offset_loop_off)
    else $error("second amp loop outputs differ");
  a_limit_level_off: assert property (!second_amp_limit_on |-> !second_amp_output_limit_level)
    else $error("limit level set while limit off");
  a_highz_map_zero: assert property (term_high_z |-> term_resistor_map == 5'h00)
    else $error("resistor map active in high impedance");
  a_inlim_onehot: assert property ($onehot(input_limit_select))
    else $error("input limit not one-hot");
  a_iamp_loop_pair: assert property (input_amp_highpass_off == input_amp_offset_loop_off)
    else $error("input amp loop outputs differ");
  a_pmode_onehot: assert property ($onehot(power_mode_select))
    else $error("power mode not one-hot");
  a_igain_onehot: assert property ($onehot(input_amp_gain_select))
    else $error("input gain not one-hot");
  a_reset_decode: assert property (disable iff (1'b0) sys_rst [*3] |-> outs == 28'h2201111)
    else $error("controls not at reset decode");
  a_idle_hold: assert property (cfg_sen_n [*3] |-> $stable(outs))
    else $error("controls changed without a frame");
  c_high_z: cover property (term_high_z);
  c_level_low_power: cover property (second_amp_output_limit_level && power_mode_select[1]);
  c_read_frame: cover property (!cfg_sen_n && cfg_read_en);
endmodule // fegt_bank_sva

// file: tb/tb.sv
/* Self-checking bench for the gain and termination bank.
   Assumes the bank and its header are compiled first. */
`timescale 1ns/1ps
module tb;
  typedef struct packed {
    logic [15:0] pm;
    logic [15:0] a;
    logic [15:0] t;
    logic [27:0] e;
  } fegt_row_t;
  // Clock, reset and serial port
  logic        clock;
  logic        sys_rst;
  logic        cfg_sclk;
  logic        cfg_sen_n;
  logic        cfg_sdata;
  logic        cfg_read_en;
  wire         cfg_sdout;
  wire  [27:0] outs;
  int          error_cnt;
  int          samples_checked;
  logic [15:0] rd;
  fegt_row_t   rows [0:8];

  fegt_bank u_fegt_bank (.clock(clock), .sys_rst(sys_rst), .cfg_sclk(cfg_sclk),
    .cfg_sen_n(cfg_sen_n), .cfg_sdata(cfg_sdata), .cfg_read_en(cfg_read_en),
    .cfg_sdout(cfg_sdout), .lowpass_cutoff_select(outs[27:24]),
    .second_amp_offset_loop_off(outs[23]), .second_amp_highpass_off(outs[22]),
    .second_amp_limit_on(outs[21]), .second_amp_output_limit_level(outs[20]),
    .second_amp_gain_select(outs[19]), .term_active_on(outs[18]), .term_high_z(outs[17]),
    .term_resistor_map(outs[16:12]), .input_limit_select(outs[11:8]),
    .input_amp_offset_loop_off(outs[7]), .input_amp_highpass_off(outs[6]),
    .input_amp_gain_select(outs[5:3]), .power_mode_select(outs[2:0]));

  // Bits b are second amp loop, limit on, level, gain, termination on, high z
  function automatic logic [27:0] ex(input logic [3:0] lp, input logic [5:0] b,
    input logic [4:0] mp, input logic [3:0] il, input logic ilp, input logic [2:0] ig, pm);
    return {lp, b[5], b, mp, il, ilp, ilp, ig, pm};
  endfunction

  task automatic chk(input logic [27:0] got, input logic [27:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic finish_test;
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Each serial level is held at least two clocks so the bank sees every edge
  task automatic xfer(input logic r, input int nb, input logic [7:0] ad, input logic [15:0] d);
    logic [23:0] w;
    w = {ad, d};
    @(posedge clock);
    cfg_sen_n   <= 1'b0;
    cfg_read_en <= r;
    for (int i = 23; i >= 24 - nb; i--) begin
      @(posedge clock);
      cfg_sclk  <= 1'b0;
      cfg_sdata <= w[i];
      repeat (2) @(posedge clock);
      @(negedge clock);
      if (i < 16) rd = {rd[14:0], cfg_sdout};
      @(posedge clock);
      cfg_sclk <= 1'b1;
      @(posedge clock);
    end
    @(posedge clock);
    cfg_sclk <= 1'b0;
    @(posedge clock);
    cfg_sen_n   <= 1'b1;
    cfg_read_en <= 1'b0;
    repeat (3) @(posedge clock);
    @(negedge clock);
  endtask

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  initial begin
    repeat (20000) @(posedge clock);
    error_cnt++;
    finish_test;
  end

  initial begin
    {sys_rst, cfg_sclk, cfg_sen_n, cfg_sdata, cfg_read_en} = 5'h14;
    error_cnt = 0;
    samples_checked = 0;
    rd = 16'h0000;
    rows[0] = '{16'h0000, 16'h0000, 16'h0000, ex(4'h2, 6'h10, 5'h01, 4'h1, 1'h0, 3'h2, 3'h1)};
    rows[1] = '{16'h0000, 16'h0004, 16'h0140, ex(4'h4, 6'h12, 5'h02, 4'h1, 1'h0, 3'h2, 3'h1)};
    rows[2] = '{16'h0000, 16'h0056, 16'h0280, ex(4'h8, 6'h38, 5'h04, 4'h2, 1'h0, 3'h2, 3'h1)};
    rows[3] = '{16'h0000, 16'h0088, 16'h04C0, ex(4'h1, 6'h00, 5'h08, 4'h4, 1'h0, 3'h2, 3'h1)};
    rows[4] = '{16'h0400, 16'h2080, 16'h1600, ex(4'h2, 6'h14, 5'h01, 4'h8, 1'h1, 3'h2, 3'h2)};
    rows[5] = '{16'h0400, 16'h00C0, 16'h4000, ex(4'h2, 6'h19, 5'h00, 4'h1, 1'h0, 3'h1, 3'h2)};
    rows[6] = '{16'h0800, 16'h0040, 16'h4035, ex(4'h2, 6'h00, 5'h15, 4'h1, 1'h0, 3'h1, 3'h4)};
    rows[7] = '{16'h0800, 16'h00C0, 16'h2055, ex(4'h2, 6'h18, 5'h02, 4'h1, 1'h0, 3'h4, 3'h4)};
    rows[8] = '{16'h0400, 16'h0000, 16'h4100, ex(4'h2, 6'h03, 5'h00, 4'h1, 1'h0, 3'h1, 3'h2)};
    repeat (10) @(posedge clock);
    @(negedge clock);
    chk(outs, rows[0].e);
    @(posedge clock);
    sys_rst <= 1'b0;
    for (int i = 0; i < 9; i++) begin
      xfer(1'b0, 24, 8'h35, rows[i].pm);
      xfer(1'b0, 24, 8'h33, rows[i].a);
      xfer(1'b0, 24, 8'h34, rows[i].t);
      chk(outs, rows[i].e);
    end
    // A frame cut short and an unmapped address must leave the bank alone
    xfer(1'b0, 12, 8'h33, 16'hFFFF);
    xfer(1'b0, 24, 8'h36, 16'hFFFF);
    chk(outs, rows[8].e);
    xfer(1'b1, 24, 8'h36, 16'h0000);
    chk({12'h000, rd}, 28'h0000000);
    xfer(1'b0, 24, 8'h34, 16'hFFFF);
    chk({23'h000000, outs[16:12]}, 28'h000001F);
    xfer(1'b1, 24, 8'h34, 16'h0000);
    chk({12'h000, rd}, 28'h00077FF);
    chk({23'h000000, outs[16:12]}, 28'h000001F);
    // Reserved power code keeps the low-noise clamp sense
    xfer(1'b0, 24, 8'h35, 16'h0C00);
    chk({23'h000000, outs[21:20], outs[2:0]}, 28'h0000011);
    @(posedge clock);
    sys_rst <= 1'b1;
    repeat (3) @(posedge clock);
    @(negedge clock);
    chk(outs, rows[0].e);
    @(posedge clock);
    sys_rst <= 1'b0;
    xfer(1'b1, 24, 8'h34, 16'h0000);
    chk({12'h000, rd}, 28'h0000000);
    finish_test;
  end
endmodule // tb

bind fegt_bank fegt_bank_sva u_fegt_bank_sva (.clock(clock), .sys_rst(sys_rst),
  .cfg_sen_n(cfg_sen_n), .cfg_read_en(cfg_read_en),
  .lowpass_cutoff_select(lowpass_cutoff_select),
  .second_amp_offset_loop_off(second_amp_offset_loop_off),
  .second_amp_highpass_off(second_amp_highpass_off),
  .second_amp_limit_on(second_amp_limit_on),
  .second_amp_output_limit_level(second_amp_output_limit_level),
  .second_amp_gain_select(second_amp_gain_select), .term_active_on(term_active_on),
  .term_high_z(term_high_z), .term_resistor_map(term_resistor_map),
  .input_limit_select(input_limit_select),
  .input_amp_offset_loop_off(input_amp_offset_loop_off),
  .input_amp_highpass_off(input_amp_highpass_off),
  .input_amp_gain_select(input_amp_gain_select), .power_mode_select(power_mode_select));
